// ---- core/pll_cal_params.svh ----
// Register indices, field layout, reset values and settle times of the PLL calibration controls
`ifndef PLL_CAL_PARAMS_SVH
`define PLL_CAL_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_FILTER_ORDER  8'h76
`define IDX_CAL_WAITS     8'h77
`define IDX_BW_MODE       8'h78
`define IDX_CAL_CONTROL   8'h79
`define IDX_PULSE_STRETCH 8'h83

`define ORDER_MSB 2
`define ORDER_LSB 0
`define CLSD_MSB  3
`define CLSD_LSB  2
`define VCO_MSB   1
`define VCO_LSB   0
`define BW_BIT    0
`define WIDEN_BIT 7
`define START_BIT 0

`define ORDER_RST 3'h3
`define CLSD_RST  2'h0
`define VCO_RST   2'h1
`define BW_RST    1'h0
`define WIDEN_RST 1'h0

`define ORDER_SECOND 3'h3
`define ORDER_THIRD  3'h7

`define PULSE_NARROW_PS 10'h0C8
`define PULSE_WIDE_PS   10'h258

`define CLK_PERIOD_NS 10
`define CLSD_T0_US    30
`define CLSD_T1_US    300
`define CLSD_T2_MS    30
`define CLSD_T3_MS    300
`define VCO_T0_US     20
`define VCO_T1_US     400
`define VCO_T2_MS     8
`define VCO_T3_MS     200
`define CLSD_C0       ((`CLSD_T0_US * 1000) / `CLK_PERIOD_NS)
`define VCO_C0        ((`VCO_T0_US * 1000) / `CLK_PERIOD_NS)

`define CNT_W 25

`endif

// ---- core/pll_cal_pkg.sv ----
// Types shared by the PLL calibration control block
`include "pll_cal_params.svh"
package pll_cal_pkg;
  typedef enum logic [3:0] {
    CAL_IDLE    = 4'h1,
    CAL_OSC     = 4'h2,
    CAL_LOOP    = 4'h4,
    CAL_SETTLED = 4'h8
  } cal_state_e;

  typedef logic [`CNT_W-1:0] wait_count_t;
endpackage : pll_cal_pkg

// ---- core/pll_loop_calibration_controls.sv ----
// PLL loop filter, calibration wait, bandwidth and pulse stretch registers on APB
// Operation
// - Filter order code 3 selects the second-order loop filter.
// - Filter order code 7 selects the third-order loop filter.
// - Closed-loop wait code gives 30 us, 300 us, 30 ms or 300 ms.
// - Oscillator wait code gives 20 us, 400 us, 8 ms or 200 ms.
// - Bandwidth bit 1 narrows first PLL bandwidth to 200 Hz.
// - Bandwidth bit 0 keeps first PLL at normal bandwidth range.
// - Stretch bit 0 gives 200 ps minimum detector pulse width.
// - Stretch bit 1 widens minimum detector pulse to about 600 ps.
//
// The APB interface to the registers was chosen for this implementation.
`include "pll_cal_params.svh"
module pll_loop_calibration_controls #(
  parameter int CLSD_WAIT1_CYC = (`CLSD_T1_US * 1000) / `CLK_PERIOD_NS,
  parameter int CLSD_WAIT2_CYC = (`CLSD_T2_MS * 1000000) / `CLK_PERIOD_NS,
  parameter int CLSD_WAIT3_CYC = (`CLSD_T3_MS * 1000000) / `CLK_PERIOD_NS,
  parameter int VCO_WAIT1_CYC  = (`VCO_T1_US * 1000) / `CLK_PERIOD_NS,
  parameter int VCO_WAIT2_CYC  = (`VCO_T2_MS * 1000000) / `CLK_PERIOD_NS,
  parameter int VCO_WAIT3_CYC  = (`VCO_T3_MS * 1000000) / `CLK_PERIOD_NS
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output logic [31:0]                   prdata,
  output logic                          pslverr,
  output logic [2:0]                    first_loop_filter_order_sel,
  output logic                          second_order_filter_en,
  output logic                          third_order_filter_en,
  output logic [1:0]                    first_closed_loop_settle_sel,
  output logic [1:0]                    first_oscillator_settle_sel,
  output logic                          first_narrow_bandwidth_sel,
  output logic                          jitter_cleaner_en,
  output logic                          normal_bandwidth_en,
  output logic                          second_detector_pulse_widen,
  output logic [9:0]                    detector_min_pulse_ps,
  output pll_cal_pkg::cal_state_e       cal_state,
  output logic                          oscillator_settling,
  output logic                          closed_loop_settling
);
  import pll_cal_pkg::*;

  logic        hit_order;
  logic        hit_waits;
  logic        hit_bw;
  logic        hit_ctrl;
  logic        hit_widen;
  logic        mapped;
  logic        wr_en;
  logic        rd_setup;
  logic [7:0]  rd_byte;
  logic [31:0] prdata_q;
  logic [2:0]  wr_order_val;

  logic [2:0]  order_q;
  logic [2:0]  order_d;
  logic [1:0]  clsd_q;
  logic [1:0]  clsd_d;
  logic [1:0]  vco_q;
  logic [1:0]  vco_d;
  logic        bw_q;
  logic        bw_d;
  logic        widen_q;
  logic        widen_d;
  logic        second_q;
  logic        third_q;
  logic        reserved_q;
  logic        jitter_q;
  logic        normal_q;
  logic [9:0]  pulse_ps_q;

  cal_state_e  state_q;
  cal_state_e  state_d;
  logic        start_req;
  logic        tmr_load;
  wait_count_t tmr_val;
  logic        tmr_expired;
  logic        tmr_running;

  // Settle lengths in clock cycles, indexed by wait code
  localparam wait_count_t LOOP_TAB [4] = '{wait_count_t'(`CLSD_C0), wait_count_t'(CLSD_WAIT1_CYC),
                                           wait_count_t'(CLSD_WAIT2_CYC), wait_count_t'(CLSD_WAIT3_CYC)};
  localparam wait_count_t OSC_TAB [4]  = '{wait_count_t'(`VCO_C0), wait_count_t'(VCO_WAIT1_CYC),
                                           wait_count_t'(VCO_WAIT2_CYC), wait_count_t'(VCO_WAIT3_CYC)};

  // APB decode; zero wait states, error on unmapped addresses
  assign hit_order = (paddr == {2'h0, `IDX_FILTER_ORDER, 2'h0});
  assign hit_waits = (paddr == {2'h0, `IDX_CAL_WAITS, 2'h0});
  assign hit_bw    = (paddr == {2'h0, `IDX_BW_MODE, 2'h0});
  assign hit_ctrl  = (paddr == {2'h0, `IDX_CAL_CONTROL, 2'h0});
  assign hit_widen = (paddr == {2'h0, `IDX_PULSE_STRETCH, 2'h0});
  assign mapped    = hit_order | hit_waits | hit_bw | hit_ctrl | hit_widen;

  assign pready       = 1'b1;
  assign pslverr      = psel && penable && !mapped;
  assign wr_en        = psel && penable && pwrite && mapped && pstrb[0];
  assign rd_setup     = psel && !penable && !pwrite;
  assign start_req    = wr_en && hit_ctrl && pwdata[`START_BIT];
  assign wr_order_val = pwdata[`ORDER_MSB:`ORDER_LSB];

  // Only field bits are stored, reserved bits are dropped
  always_comb
  begin
    order_d = order_q;
    clsd_d  = clsd_q;
    vco_d   = vco_q;
    bw_d    = bw_q;
    widen_d = widen_q;
    if (wr_en && hit_order)
      order_d = wr_order_val;
    if (wr_en && hit_waits)
    begin
      clsd_d = pwdata[`CLSD_MSB:`CLSD_LSB];
      vco_d  = pwdata[`VCO_MSB:`VCO_LSB];
    end
    if (wr_en && hit_bw)
      bw_d = pwdata[`BW_BIT];
    if (wr_en && hit_widen)
      widen_d = pwdata[`WIDEN_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      order_q <= `ORDER_RST;
      clsd_q  <= `CLSD_RST;
      vco_q   <= `VCO_RST;
      bw_q    <= `BW_RST;
      widen_q <= `WIDEN_RST;
    end
    else
    begin
      order_q <= order_d;
      clsd_q  <= clsd_d;
      vco_q   <= vco_d;
      bw_q    <= bw_d;
      widen_q <= widen_d;
    end
  end

  // Analog settings decoded into flops, aligned with the fields
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      second_q   <= 1'b1;
      third_q    <= 1'b0;
      reserved_q <= 1'b0;
      jitter_q   <= 1'b0;
      normal_q   <= 1'b1;
      pulse_ps_q <= `PULSE_NARROW_PS;
    end
    else
    begin
      second_q   <= (order_d == `ORDER_SECOND);
      third_q    <= (order_d == `ORDER_THIRD);
      reserved_q <= (order_d != `ORDER_SECOND) && (order_d != `ORDER_THIRD);
      jitter_q   <= bw_d;
      normal_q   <= !bw_d;
      pulse_ps_q <= widen_d ? `PULSE_WIDE_PS : `PULSE_NARROW_PS;
    end
  end

  // Read data captured in the setup phase, valid through the access phase
  always_comb
  begin
    rd_byte = 8'h00;
    if (hit_order)
      rd_byte = {5'h00, order_q};
    else if (hit_waits)
      rd_byte = {4'h0, clsd_q, vco_q};
    else if (hit_bw)
      rd_byte = {7'h00, bw_q};
    else if (hit_ctrl)
      rd_byte = {3'h0, reserved_q, state_q};
    else if (hit_widen)
      rd_byte = {widen_q, 7'h00};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata_q <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Calibration sequence: oscillator wait, then closed-loop wait
  always_comb
  begin
    state_d  = state_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    unique case (state_q)
      CAL_IDLE, CAL_SETTLED:
      begin
        if (start_req)
        begin
          state_d  = CAL_OSC;
          tmr_load = 1'b1;
          tmr_val  = OSC_TAB[vco_q];
        end
      end
      CAL_OSC:
      begin
        if (tmr_expired)
        begin
          state_d  = CAL_LOOP;
          tmr_load = 1'b1;
          tmr_val  = LOOP_TAB[clsd_q];
        end
      end
      CAL_LOOP:
      begin
        if (tmr_expired)
        begin
          state_d = CAL_SETTLED;
        end
      end
      default:
      begin
        state_d = CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= CAL_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  settle_wait_timer u_wait (
    .mclk       (mclk),
    .rst        (rst),
    .load       (tmr_load),
    .load_count (tmr_val),
    .expired    (tmr_expired),
    .running    (tmr_running)
  );

  assign prdata                       = prdata_q;
  assign first_loop_filter_order_sel  = order_q;
  assign second_order_filter_en       = second_q;
  assign third_order_filter_en        = third_q;
  assign first_closed_loop_settle_sel = clsd_q;
  assign first_oscillator_settle_sel  = vco_q;
  assign first_narrow_bandwidth_sel   = bw_q;
  assign jitter_cleaner_en            = jitter_q;
  assign normal_bandwidth_en          = normal_q;
  assign second_detector_pulse_widen  = widen_q;
  assign detector_min_pulse_ps        = pulse_ps_q;
  assign cal_state                    = state_q;
  assign oscillator_settling          = (state_q == CAL_OSC);
  assign closed_loop_settling         = (state_q == CAL_LOOP);

  // Helper: cycles spent in the current wait and the code it was loaded from
  wait_count_t elapsed_q;
  logic [1:0]  code_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      elapsed_q <= '0;
      code_q    <= 2'h0;
    end
    else if (tmr_load)
    begin
      elapsed_q <= '0;
      code_q    <= (state_q == CAL_OSC) ? clsd_q : vco_q;
    end
    else if (tmr_running)
    begin
      elapsed_q <= elapsed_q + wait_count_t'(1);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_second_order;
    order_q == `ORDER_SECOND |-> second_order_filter_en && !third_order_filter_en;
  endproperty
  a_second_order: assert property (p_second_order)
    else $error("code 3 did not select second-order filter");

  property p_third_order;
    order_q == `ORDER_THIRD |-> third_order_filter_en && !second_order_filter_en;
  endproperty
  a_third_order: assert property (p_third_order)
    else $error("code 7 did not select third-order filter");

  property p_loop_wait;
    closed_loop_settling && tmr_expired |-> elapsed_q == LOOP_TAB[code_q] - wait_count_t'(1);
  endproperty
  a_loop_wait: assert property (p_loop_wait)
    else $error("closed-loop wait length wrong");
  property p_osc_wait;
    oscillator_settling && tmr_expired |-> elapsed_q == OSC_TAB[code_q] - wait_count_t'(1)
      ##1 closed_loop_settling;
  endproperty
  a_osc_wait: assert property (p_osc_wait)
    else $error("oscillator wait length wrong");

  property p_narrow_bw;
    first_narrow_bandwidth_sel |-> jitter_cleaner_en && !normal_bandwidth_en;
  endproperty
  a_narrow_bw: assert property (p_narrow_bw)
    else $error("narrow bandwidth not applied");

  property p_normal_bw;
    !first_narrow_bandwidth_sel |-> normal_bandwidth_en && !jitter_cleaner_en;
  endproperty
  a_normal_bw: assert property (p_normal_bw)
    else $error("normal bandwidth not applied");

  property p_pulse_narrow;
    !second_detector_pulse_widen |-> detector_min_pulse_ps == `PULSE_NARROW_PS;
  endproperty
  a_pulse_narrow: assert property (p_pulse_narrow)
    else $error("minimum pulse not 200 ps");

  property p_pulse_wide;
    second_detector_pulse_widen |-> detector_min_pulse_ps == `PULSE_WIDE_PS;
  endproperty
  a_pulse_wide: assert property (p_pulse_wide)
    else $error("minimum pulse not widened");

  property p_write_read;
    wr_en && hit_order |=> order_q == $past(wr_order_val);
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("filter order not stored");

  property p_read_back;
    rd_setup && hit_order |=> prdata[7:0] == {5'h00, order_q};
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("filter order read back wrong");

  c_start: cover property (start_req && state_q == CAL_IDLE);
  c_settled: cover property (closed_loop_settling ##1 state_q == CAL_SETTLED);
  c_reserved: cover property (wr_en && hit_order && wr_order_val == 3'h0);
  c_unmapped: cover property (pslverr);
endmodule : pll_loop_calibration_controls

// ---- core/settle_wait_timer.sv ----
// Down counter that times one settle period in clock cycles
`include "pll_cal_params.svh"
module settle_wait_timer (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      load,
  input  wire pll_cal_pkg::wait_count_t  load_count,
  output logic                           expired,
  output logic                           running
);
  import pll_cal_pkg::*;

  wait_count_t cnt_q;
  logic        running_q;

  assign expired = running_q && (cnt_q == '0);
  assign running = running_q;

  // Load of N holds the timer for exactly N cycles
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q     <= '0;
      running_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q     <= load_count - wait_count_t'(1);
      running_q <= 1'b1;
    end
    else if (expired)
    begin
      running_q <= 1'b0;
    end
    else if (running_q)
    begin
      cnt_q <= cnt_q - wait_count_t'(1);
    end
  end

  // A reload in the expiry cycle starts the next period
  property p_done_ends_run;
    @(posedge mclk) disable iff (rst) expired && !load |=> !running_q;
  endproperty
  a_done_ends_run: assert property (p_done_ends_run)
    else $error("timer still running after expiry");
endmodule : settle_wait_timer

// ---- dv/pll_loop_calibration_controls_bench.sv ----
// Self-checking bench for the PLL loop filter, calibration wait, bandwidth and stretch registers
`include "pll_cal_params.svh"
module pll_loop_calibration_controls_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int V1 = 40;
  localparam int V2 = 45;
  localparam int V3 = 55;
  localparam int C1 = 50;
  localparam int C2 = 60;
  localparam int C3 = 70;
  localparam int OSC_CYC [4]  = '{`VCO_C0, V1, V2, V3};
  localparam int LOOP_CYC [4] = '{`CLSD_C0, C1, C2, C3};
  localparam logic [7:0] IDX_TAB [4]  = '{`IDX_FILTER_ORDER, `IDX_CAL_WAITS, `IDX_BW_MODE, `IDX_PULSE_STRETCH};
  localparam logic [7:0] MASK_TAB [4] = '{8'h07, 8'h0F, 8'h01, 8'h80};
  localparam logic [7:0] RST_TAB [4]  = '{8'h03, 8'h01, 8'h00, 8'h00};

  logic                     mclk;
  logic                     rst;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic [2:0]               order_sel;
  logic                     second_en;
  logic                     third_en;
  logic [1:0]               closed_sel;
  logic [1:0]               osc_sel;
  logic                     narrow_sel;
  logic                     jitter_en;
  logic                     normal_en;
  logic                     widen;
  logic [9:0]               pulse_ps;
  pll_cal_pkg::cal_state_e  cal_state;
  logic                     osc_settling;
  logic                     loop_settling;
  logic [7:0]               sh [4];
  int                       miscompares;
  int                       total_checks;

  pll_loop_calibration_controls #(
    .CLSD_WAIT1_CYC(C1), .CLSD_WAIT2_CYC(C2), .CLSD_WAIT3_CYC(C3),
    .VCO_WAIT1_CYC(V1), .VCO_WAIT2_CYC(V2), .VCO_WAIT3_CYC(V3)
  ) u_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .first_loop_filter_order_sel(order_sel), .second_order_filter_en(second_en),
    .third_order_filter_en(third_en), .first_closed_loop_settle_sel(closed_sel),
    .first_oscillator_settle_sel(osc_sel), .first_narrow_bandwidth_sel(narrow_sel),
    .jitter_cleaner_en(jitter_en), .normal_bandwidth_en(normal_en),
    .second_detector_pulse_widen(widen), .detector_min_pulse_ps(pulse_ps), .cal_state(cal_state),
    .oscillator_settling(osc_settling), .closed_loop_settling(loop_settling)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic final_report();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One APB transfer; holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [7:0] wd, input logic [3:0] strb,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {24'($urandom()), wd};
    pstrb   <= strb;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge mclk);
      n++;
    end
    if (n >= 50)
      check(32'h0, 32'h1, "pready never came");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] v;
    logic        e;
    apb(1'b1, {2'h0, idx, 2'h0}, d, 4'hF, v, e);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    logic e;
    apb(1'b0, {2'h0, idx, 2'h0}, 8'h00, 4'hF, v, e);
  endtask : rd

  // Decoded outputs against the shadow copy of the registers
  task automatic check_outs();
    // Look after the edge that updated the fields
    @(negedge mclk);
    check(order_sel, sh[0][2:0], "filter order");
    check(second_en, sh[0][2:0] == 3'h3, "second order enable");
    check(third_en, sh[0][2:0] == 3'h7, "third order enable");
    check(closed_sel, sh[1][3:2], "closed loop code");
    check(osc_sel, sh[1][1:0], "oscillator code");
    check(jitter_en, sh[2][0], "narrow bandwidth");
    check(normal_en, !sh[2][0], "normal bandwidth");
    check(narrow_sel, sh[2][0], "bandwidth bit");
    check(widen, sh[3][7], "stretch bit");
    check(pulse_ps, sh[3][7] ? 10'h258 : 10'h0C8, "detector pulse");
  endtask : check_outs

  initial
  begin
    #500000;
    miscompares++;
    $display("watchdog expired");
    final_report();
  end

  initial
  begin
    logic [31:0] v;
    logic        e;
    logic [7:0]  d;
    logic [2:0]  c;
    int          i;
    int          n;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    miscompares = 0;
    total_checks = 0;
    void'($urandom(32'hFD436540));
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      rd(IDX_TAB[i], v);
      check(v, {24'h0, RST_TAB[i]}, "reset value");
      sh[i] = RST_TAB[i];
    end
    check_outs();
    check(cal_state, pll_cal_pkg::CAL_IDLE, "idle after reset");
    $display("test reset values done");
    for (i = 0; i < 8; i++)
    begin
      c = i[0] ? `ORDER_THIRD : `ORDER_SECOND;
      wr(IDX_TAB[0], {5'($urandom()), c});
      sh[0] = {5'h00, c};
      check_outs();
      rd(IDX_TAB[0], v);
      check(v, {24'h0, sh[0]}, "filter code readback");
    end
    $display("test filter codes done");
    for (n = 0; n < 40; n++)
    begin
      i = $urandom_range(3, 0);
      d = 8'($urandom());
      if (i == 0)
        d[2:0] = d[0] ? `ORDER_THIRD : `ORDER_SECOND;
      wr(IDX_TAB[i], d);
      sh[i] = d & MASK_TAB[i];
      rd(IDX_TAB[i], v);
      check(v, {24'h0, sh[i]}, "random readback");
      check_outs();
      if (i == 2)
      begin
        sh[1] = {4'h0, d[0] ? 2'h3 : 2'h1, 2'h1};
        wr(IDX_TAB[1], sh[1]);
        check_outs();
      end
    end
    $display("test random access done");
    apb(1'b1, {2'h0, IDX_TAB[3], 2'h0}, ~sh[3], 4'h0, v, e);
    check_outs();
    check(e, 1'b0, "strobe-less write error");
    apb(1'b0, 12'h100, 8'h00, 4'hF, v, e);
    check(e, 1'b1, "unmapped error");
    check(v, 32'h0, "unmapped data");
    $display("test refused accesses done");
    wr(IDX_TAB[0], 8'h03);
    sh[0] = 8'h03;
    for (i = 0; i < 4; i++)
    begin
      wr(IDX_TAB[1], {4'h0, 2'(3 - i), 2'(i)});
      sh[1] = {4'h0, 2'(3 - i), 2'(i)};
      check_outs();
      wr(`IDX_CAL_CONTROL, 8'h01);
      n = 0;
      @(negedge mclk);
      while (osc_settling === 1'b1 && n < 3000)
      begin
        n++;
        @(negedge mclk);
      end
      check(n, OSC_CYC[i], "oscillator settle cycles");
      n = 0;
      while (loop_settling === 1'b1 && n < 4000)
      begin
        n++;
        @(negedge mclk);
      end
      check(n, LOOP_CYC[3 - i], "closed loop settle cycles");
      check(cal_state, pll_cal_pkg::CAL_SETTLED, "settled");
      rd(`IDX_CAL_CONTROL, v);
      check(v, 32'h08, "status readback");
    end
    $display("test calibration waits done");
    final_report();
  end
endmodule : pll_loop_calibration_controls_bench
